//--- design/cafb_pkg.sv
// Purpose: shared constants and carriers of the acceptance filter block
// Assumes: AHB-Lite bus with 32-bit data, one register per aligned word
// Notes:   register bytes sit in the low eight bits of each word; FEN and STAT use the low sixteen
package cafb_pkg;

	// sizes of the block
	localparam int unsigned NUM_BUF     = 6;
	localparam int unsigned NUM_FILT    = 16;
	localparam int unsigned NUM_MASK    = 2;
	localparam logic [3:0]  FILT_MODE0  = 4'h6;  // first filter gone in mode 0

	// register byte offsets
	localparam logic [11:0] ADDR_MODE   = 12'h000;
	localparam logic [11:0] ADDR_DIR    = 12'h004;
	localparam logic [11:0] ADDR_FEN    = 12'h008;
	localparam logic [11:0] ADDR_STAT   = 12'h00C;
	localparam logic [11:0] ADDR_TXLEN  = 12'h020;  // six words, stride 4
	localparam logic [11:0] ADDR_FILT   = 12'h100;  // 16 x 4 words
	localparam logic [11:0] ADDR_MASK   = 12'h200;  // 2 x 4 words
	localparam logic [11:0] MASK_TXLEN  = 12'hFE0;
	localparam logic [11:0] MASK_FILT   = 12'hF00;
	localparam logic [11:0] MASK_MASK   = 12'hFE0;

	// byte index inside one filter or mask group
	localparam logic [1:0]  SUB_SIDH    = 2'h0;
	localparam logic [1:0]  SUB_SIDL    = 2'h1;
	localparam logic [1:0]  SUB_EIDH    = 2'h2;
	localparam logic [1:0]  SUB_EIDL    = 2'h3;

	// field positions and masks
	localparam int unsigned TXLEN_RTR_BIT = 6;
	localparam int unsigned SIDL_EXT_BIT  = 3;
	localparam logic [7:0]  SIDL_KEEP     = 8'hEB;  // bits 4 and 2 absent
	localparam logic [7:0]  SIDL_KEEP_MSK = 8'hE3;  // bit 3 kept apart
	localparam logic [3:0]  DLC_MAX       = 4'h8;

	// mode codes
	localparam logic [1:0]  MODE_LEGACY   = 2'h0;
	localparam logic [1:0]  MODE_LAST     = 2'h2;

	// values after reset
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [5:0]  DIR_RST       = 6'h00;
	localparam logic [15:0] FEN_RST       = 16'h103F;

	// decoded register kinds
	localparam logic [2:0]  K_NONE  = 3'h0;
	localparam logic [2:0]  K_MODE  = 3'h1;
	localparam logic [2:0]  K_DIR   = 3'h2;
	localparam logic [2:0]  K_FEN   = 3'h3;
	localparam logic [2:0]  K_STAT  = 3'h4;
	localparam logic [2:0]  K_TXLEN = 3'h5;
	localparam logic [2:0]  K_FILT  = 3'h6;
	localparam logic [2:0]  K_MASK  = 3'h7;

	typedef struct packed {
		logic [2:0] kind;
		logic [3:0] idx;
		logic [1:0] sub;
	} cafb_dec_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} cafb_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} cafb_ahb_rsp_t;

	// frame identifier from the protocol engine
	typedef struct packed {
		logic        valid;
		logic        ext;
		logic [28:0] id;
	} cafb_rx_t;

	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [3:0] idx;
	} cafb_acc_t;

	// per-buffer transmit setup towards the protocol engine
	typedef struct packed {
		logic [5:0]  dir;
		logic [5:0]  rtr;
		logic [23:0] bytes;
	} cafb_tx_t;

endpackage // cafb_pkg

//--- design/cafb_top.sv
// Purpose: buffer setup registers and acceptance filters behind AHB-Lite
// Assumes: frame identifiers arrive on the same clock as the bus
// Notes:   reads take one wait state, writes none
//
// Notes on behaviour
// - transmit buffer remote-request bit sets the frame's RTR bit
// - length code 0 to 8 gives byte count; 9 to 15 reserved
// - length register bits 7, 5, 4 read zero
// - length register exists only in modes 1 and 2
// - direction bits 7..2 pick buffers 5..0, 1 transmit; bits 1..0 zero
// - direction register only in modes 1, 2; resets to all receive
// - sixteen filters; filters 6 to 15 only in modes 1 and 2
// - filter high byte holds identifier bits 10..3 or 28..21
// - filter low byte: bits 7..5, ext-select, 1..0; bits 4, 2 zero
// - filter ext-select picks extended-only or standard-only frames
// - filter extended bytes 15..8 and 7..0; high filters modes 1, 2
// - two masks; high byte covers bits 10..3 or 28..21
// - mask low byte like filter low byte; bits 4, 2 zero
// - mask extended bytes cover bits 15..8 and 7..0
// - mask ext-select restricts frame type, cleared accepts both
// - mask ext-select only in modes 1, 2, resets zero, else reads zero
// - each filter has its own enable bit
module cafb_top
(
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	input  wire cafb_pkg::cafb_ahb_req_t i_bus,
	output      cafb_pkg::cafb_ahb_rsp_t o_bus,
	input  wire cafb_pkg::cafb_rx_t      i_rx,
	output      cafb_pkg::cafb_acc_t     o_acc,
	output      cafb_pkg::cafb_tx_t      o_tx
);

	typedef struct packed {
		logic [1:0]          mode;
		logic [5:0]          dir;
		logic [15:0]         fen;
		logic [5:0]          rtr;
		logic [23:0]         dlc;
		logic [1:0]          mext;
		logic                ap_vld;
		logic                ap_wr;
		logic [11:0]         ap_addr;
		logic [31:0]         hrdata;
		logic                hready;
		logic [7:0]          hits;
		cafb_pkg::cafb_acc_t acc;
		cafb_pkg::cafb_tx_t  tx;
	} cafb_state_t;

	cafb_state_t         st_r;
	cafb_state_t         st_nxt;
	logic [7:0]          filt_mem [cafb_pkg::NUM_FILT][4];
	logic [7:0]          mask_mem [cafb_pkg::NUM_MASK][4];
	logic                mem_we_f;
	logic                mem_we_m;
	logic [3:0]          mem_idx;
	logic [1:0]          mem_sub;
	logic [7:0]          mem_byte;
	cafb_pkg::cafb_dec_t dcur;
	logic                take;

	// address decode shared by read and write paths
	function automatic cafb_pkg::cafb_dec_t dec(input logic [11:0] a);
		cafb_pkg::cafb_dec_t d;
		d      = '0;
		d.idx  = a[7:4];
		d.sub  = a[3:2];
		if (a == cafb_pkg::ADDR_MODE)
			d.kind = cafb_pkg::K_MODE;
		else if (a == cafb_pkg::ADDR_DIR)
			d.kind = cafb_pkg::K_DIR;
		else if (a == cafb_pkg::ADDR_FEN)
			d.kind = cafb_pkg::K_FEN;
		else if (a == cafb_pkg::ADDR_STAT)
			d.kind = cafb_pkg::K_STAT;
		else if ((a & cafb_pkg::MASK_TXLEN) == cafb_pkg::ADDR_TXLEN
			&& a[4:2] < 3'(cafb_pkg::NUM_BUF) && a[1:0] == 2'h0)
		begin
			d.kind = cafb_pkg::K_TXLEN;
			d.idx  = {1'b0, a[4:2]};
		end
		else if ((a & cafb_pkg::MASK_FILT) == cafb_pkg::ADDR_FILT
			&& a[1:0] == 2'h0)
			d.kind = cafb_pkg::K_FILT;
		else if ((a & cafb_pkg::MASK_MASK) == cafb_pkg::ADDR_MASK
			&& a[1:0] == 2'h0)
		begin
			d.kind = cafb_pkg::K_MASK;
			d.idx  = {3'h0, a[4]};
		end
		return d;
	endfunction

	// four stored bytes to a 29-bit identifier pattern
	function automatic logic [28:0] id29(input logic [7:0] hi,
		input logic [7:0] lo, input logic [7:0] eh, input logic [7:0] el);
		return {hi, lo[7:5], lo[1:0], eh, el};
	endfunction

	// one filter against one frame under one mask
	function automatic logic filt_hit(input logic [28:0] fid,
		input logic fext, input logic [28:0] mid, input logic mext,
		input logic [1:0] mode, input cafb_pkg::cafb_rx_t rx);
		logic type_ok;
		logic id_ok;
		type_ok = 1'b1;
		// mode 0 always checks the type; software keeps ext-select right
		if (mode == cafb_pkg::MODE_LEGACY || mext)
			type_ok = (fext == rx.ext);
		if (rx.ext)
			id_ok = ((fid ^ rx.id) & mid) == 29'h0;
		else
			id_ok = ((fid[28:18] ^ rx.id[10:0]) & mid[28:18]) == 11'h0;
		return type_ok & id_ok;
	endfunction

	// mask 0 serves filters 0 and 1, mask 1 the rest
	function automatic logic mask_of(input logic [3:0] f);
		return f > 4'h1;
	endfunction

	assign dcur = dec(st_r.ap_addr);
	assign take = i_bus.hsel & i_bus.htrans[1] & i_bus.hready;

	// next state: bus slave, register updates, acceptance
	always_comb
	begin
		logic        legacy;
		logic [31:0] rd;
		logic [7:0]  wb;
		logic [28:0] fid;
		logic [28:0] mid;
		logic        mx;
		logic        any;
		logic [3:0]  first;
		logic [3:0]  d4;
		legacy   = st_r.mode == cafb_pkg::MODE_LEGACY;
		rd       = 32'h0;
		wb       = i_bus.hwdata[7:0];
		fid      = '0;
		mid      = '0;
		mx       = 1'b0;
		any      = 1'b0;
		first    = 4'h0;
		d4       = 4'h0;
		st_nxt   = st_r;
		mem_we_f = 1'b0;
		mem_we_m = 1'b0;
		mem_idx  = dcur.idx;
		mem_sub  = dcur.sub;
		mem_byte = wb;

		// read mux, unmapped words read zero
		unique case (dcur.kind)
			cafb_pkg::K_MODE:  rd = {30'h0, st_r.mode};
			cafb_pkg::K_DIR:   rd = legacy ? 32'h0
				: {24'h0, st_r.dir, 2'h0};
			cafb_pkg::K_FEN:   rd = {16'h0, st_r.fen};
			cafb_pkg::K_STAT:  rd = {16'h0, st_r.hits, 3'h0,
				st_r.acc.hit, st_r.acc.idx};
			cafb_pkg::K_TXLEN: rd = legacy ? 32'h0
				: {24'h0, 1'b0, st_r.rtr[dcur.idx[2:0]], 2'h0,
				st_r.dlc[dcur.idx[2:0]*4 +: 4]};
			cafb_pkg::K_FILT:  rd = (legacy && dcur.idx >= cafb_pkg::FILT_MODE0)
				? 32'h0 : {24'h0, filt_mem[dcur.idx][dcur.sub]};
			cafb_pkg::K_MASK:
			begin
				rd = {24'h0, mask_mem[dcur.idx[0]][dcur.sub]};
				if (dcur.sub == cafb_pkg::SUB_SIDL)
					rd[cafb_pkg::SIDL_EXT_BIT] = ~legacy
						& st_r.mext[dcur.idx[0]];
			end
			default:           rd = 32'h0;
		endcase

		// address phase, read wait state, write data phase
		if (st_r.hready)
		begin
			st_nxt.ap_vld  = take;
			st_nxt.ap_wr   = i_bus.hwrite;
			st_nxt.ap_addr = i_bus.haddr[11:0];
			st_nxt.hready  = !(take && !i_bus.hwrite);
		end
		else
		begin
			st_nxt.hready = 1'b1;
			st_nxt.hrdata = rd;
		end

		// register writes at the end of the data phase
		if (st_r.ap_vld && st_r.ap_wr && st_r.hready)
		begin
			unique case (dcur.kind)
				cafb_pkg::K_MODE:
					if (wb[1:0] <= cafb_pkg::MODE_LAST)
						st_nxt.mode = wb[1:0];
				cafb_pkg::K_DIR:
					if (!legacy)
						st_nxt.dir = wb[7:2];
				cafb_pkg::K_FEN:
					st_nxt.fen = i_bus.hwdata[15:0];
				cafb_pkg::K_TXLEN:
					if (!legacy)
					begin
						st_nxt.rtr[dcur.idx[2:0]] =
							wb[cafb_pkg::TXLEN_RTR_BIT];
						st_nxt.dlc[dcur.idx[2:0]*4 +: 4] = wb[3:0];
					end
				cafb_pkg::K_FILT:
				begin
					mem_we_f = !(legacy
						&& dcur.idx >= cafb_pkg::FILT_MODE0);
					if (dcur.sub == cafb_pkg::SUB_SIDL)
						mem_byte = wb & cafb_pkg::SIDL_KEEP;
				end
				cafb_pkg::K_MASK:
				begin
					mem_we_m = 1'b1;
					if (dcur.sub == cafb_pkg::SUB_SIDL)
					begin
						mem_byte = wb & cafb_pkg::SIDL_KEEP_MSK;
						if (!legacy)
							st_nxt.mext[dcur.idx[0]] =
								wb[cafb_pkg::SIDL_EXT_BIT];
					end
				end
				default: ;
			endcase
		end

		// acceptance: lowest-numbered enabled filter that matches wins
		for (int i = cafb_pkg::NUM_FILT - 1; i >= 0; i--)
		begin
			fid = id29(filt_mem[i][0], filt_mem[i][1],
				filt_mem[i][2], filt_mem[i][3]);
			mx  = mask_of(4'(i));
			mid = id29(mask_mem[mx][0], mask_mem[mx][1],
				mask_mem[mx][2], mask_mem[mx][3]);
			if (st_r.fen[i]
				&& (4'(i) < cafb_pkg::FILT_MODE0 || !legacy)
				&& filt_hit(fid, filt_mem[i][1][cafb_pkg::SIDL_EXT_BIT],
				mid, st_r.mext[mx], st_r.mode, i_rx))
			begin
				any   = 1'b1;
				first = 4'(i);
			end
		end
		st_nxt.acc.valid = i_rx.valid;
		st_nxt.acc.hit   = i_rx.valid & any;
		if (i_rx.valid)
			st_nxt.acc.idx = first;
		if (i_rx.valid && any)
			st_nxt.hits = st_r.hits + 8'h01;

		// transmit setup seen by the protocol engine
		st_nxt.tx.dir = legacy ? 6'h00 : st_r.dir;
		st_nxt.tx.rtr = legacy ? 6'h00 : st_r.rtr & st_r.dir;
		for (int b = 0; b < cafb_pkg::NUM_BUF; b++)
		begin
			d4 = st_r.dlc[b*4 +: 4];
			st_nxt.tx.bytes[b*4 +: 4] = (d4 > cafb_pkg::DLC_MAX)
				? cafb_pkg::DLC_MAX : d4;
		end
	end

	// control state register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r        <= '0;
			st_r.mode   <= cafb_pkg::MODE_RST;
			st_r.dir    <= cafb_pkg::DIR_RST;
			st_r.fen    <= cafb_pkg::FEN_RST;
			st_r.hready <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// identifier storage, no reset on purpose
	always_ff @(posedge i_clk)
	begin
		if (mem_we_f)
			filt_mem[mem_idx][mem_sub] <= mem_byte;
		if (mem_we_m)
			mask_mem[mem_idx[0]][mem_sub] <= mem_byte;
	end

	// outputs straight from the state register, hresp tied low
	assign o_bus.hrdata    = st_r.hrdata;
	assign o_bus.hreadyout = st_r.hready;
	assign o_bus.hresp     = 1'b0;
	assign o_acc           = st_r.acc;
	assign o_tx            = st_r.tx;

	// helpers for the checks
	logic        rd_fin;
	logic [3:0]  dlc0;
	logic [28:0] mask0_id;
	assign rd_fin   = st_r.ap_vld & ~st_r.ap_wr & ~st_r.hready;
	assign dlc0     = st_r.dlc[3:0];
	assign mask0_id = id29(mask_mem[0][0], mask_mem[0][1],
		mask_mem[0][2], mask_mem[0][3]);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	AST_TX_RTR: assert property (
		st_r.mode != cafb_pkg::MODE_LEGACY && st_r.rtr[0] && st_r.dir[0]
		|=> o_tx.rtr[0])
		else $error("rtr not passed to transmit buffer 0");
	AST_TX_BYTES: assert property (
		1'b1 |=> o_tx.bytes[3:0] == (($past(dlc0) > cafb_pkg::DLC_MAX)
		? cafb_pkg::DLC_MAX : $past(dlc0)))
		else $error("buffer 0 byte count wrong");
	AST_TXLEN_ZERO: assert property (
		rd_fin && dcur.kind == cafb_pkg::K_TXLEN
		|=> o_bus.hrdata[7] == 1'b0 && o_bus.hrdata[5:4] == 2'h0)
		else $error("length register unused bits not zero");
	AST_TXLEN_MODE0: assert property (
		rd_fin && dcur.kind == cafb_pkg::K_TXLEN
		&& st_r.mode == cafb_pkg::MODE_LEGACY |=> o_bus.hrdata == 32'h0)
		else $error("length register visible in mode 0");
	AST_DIR_LOW: assert property (
		rd_fin && dcur.kind == cafb_pkg::K_DIR |=> o_bus.hrdata[1:0] == 2'h0
		&& o_bus.hrdata[31:8] == 24'h0)
		else $error("direction register low bits not zero");
	AST_DIR_MODE0: assert property (
		st_r.mode == cafb_pkg::MODE_LEGACY |=> o_tx.dir == 6'h00)
		else $error("buffer direction active in mode 0");
	AST_FILT_HIGH_MODE0: assert property (
		rd_fin && dcur.kind == cafb_pkg::K_FILT && dcur.idx >= 4'h6
		&& st_r.mode == cafb_pkg::MODE_LEGACY |=> o_bus.hrdata == 32'h0)
		else $error("high filter visible in mode 0");
	AST_SIDL_HOLES: assert property (
		rd_fin && (dcur.kind == cafb_pkg::K_FILT
		|| dcur.kind == cafb_pkg::K_MASK) && dcur.sub == cafb_pkg::SUB_SIDL
		|=> o_bus.hrdata[4] == 1'b0 && o_bus.hrdata[2] == 1'b0)
		else $error("low identifier byte holes not zero");
	AST_MASK_EXT_MODE0: assert property (
		rd_fin && dcur.kind == cafb_pkg::K_MASK
		&& dcur.sub == cafb_pkg::SUB_SIDL
		&& st_r.mode == cafb_pkg::MODE_LEGACY |=> o_bus.hrdata[3] == 1'b0)
		else $error("mask ext-select visible in mode 0");
	AST_NO_ENABLE: assert property (
		i_rx.valid && st_r.fen == 16'h0000 |=> o_acc.valid && !o_acc.hit)
		else $error("frame accepted with all filters off");
	AST_OPEN_MASK: assert property (
		i_rx.valid && st_r.fen[0] && mask0_id == 29'h0 && !st_r.mext[0]
		&& st_r.mode != cafb_pkg::MODE_LEGACY
		|=> o_acc.hit && o_acc.idx == 4'h0)
		else $error("open mask did not accept on filter 0");
	AST_READ_WAIT: assert property (
		take && !i_bus.hwrite |=> !o_bus.hreadyout ##1 o_bus.hreadyout)
		else $error("read did not take exactly one wait state");
	AST_TYPE_RESTRICT: assert property (
		i_rx.valid && st_r.fen == 16'h0004 && st_r.mext[1]
		&& filt_mem[2][1][cafb_pkg::SIDL_EXT_BIT] != i_rx.ext
		|=> !o_acc.hit)
		else $error("filter accepted the wrong frame type");
	AST_DIR_FOLLOW: assert property (
		st_r.mode != cafb_pkg::MODE_LEGACY |=> o_tx.dir == $past(st_r.dir))
		else $error("buffer direction not passed on");

	COV_READ:   cover property (rd_fin ##1 o_bus.hreadyout);
	COV_WRITE:  cover property (st_r.ap_vld && st_r.ap_wr && st_r.hready);
	COV_HIT:    cover property (o_acc.hit && o_acc.idx > 4'h5);
	COV_MISS:   cover property (o_acc.valid && !o_acc.hit);

endmodule // cafb_top

//--- verification/cafb_engine_model.sv
// Purpose: protocol engine stand-in offering received identifiers
// Assumes: one frame offered per request pulse, same clock as the bus
// Notes:   idle lines flip each cycle so a stale id never matches
module cafb_engine_model
(
	input  wire logic               i_clk,
	input  wire logic               i_send,
	input  wire logic               i_ext,
	input  wire logic [28:0]        i_id,
	output      cafb_pkg::cafb_rx_t o_rx
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet lines at start
	initial o_rx = '0;

	// one-cycle offer, inverted lines between offers
	always @(posedge i_clk)
	begin
		o_rx.valid <= i_send;
		o_rx.ext   <= i_send ? i_ext : ~o_rx.ext;
		o_rx.id    <= i_send ? i_id : ~o_rx.id;
	end
endmodule // cafb_engine_model

//--- verification/cafb_top_tb_top.sv
// Purpose: self-checking bench of the acceptance filter block
// Assumes: AHB-Lite master here, engine model on the frame side
// Notes:   bytes of each enabled filter and its mask are written before a frame is offered
module cafb_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                    clk, nrst, hsel, hwrite, send, ext;
	logic [31:0]             haddr, hwdata, rd;
	logic [1:0]              htrans;
	logic [28:0]             id;
	int                      err_total, total_checks;
	cafb_pkg::cafb_ahb_req_t req;
	cafb_pkg::cafb_ahb_rsp_t rsp;
	cafb_pkg::cafb_rx_t      rx;
	cafb_pkg::cafb_acc_t     acc;
	cafb_pkg::cafb_tx_t      tx;
	localparam logic [11:0]  F = cafb_pkg::ADDR_FILT;
	localparam logic [11:0]  M = cafb_pkg::ADDR_MASK;
	localparam logic [11:0]  L = cafb_pkg::ADDR_TXLEN;
	localparam logic [28:0]  X = {8'hA5, 3'h3, 2'h1, 16'h3C81};

	// single slave: its ready is the bus ready
	assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata,
		rsp.hreadyout};

	cafb_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_bus(req),
		.o_bus(rsp), .i_rx(rx), .o_acc(acc), .o_tx(tx));
	cafb_engine_model eng_u (.i_clk(clk), .i_send(send),
		.i_ext(ext), .i_id(id), .o_rx(rx));

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask

	// wait for bus ready, bounded
	task automatic rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.hreadyout !== 1'b1 && n < 50);
		if (rsp.hreadyout !== 1'b1)
		begin
			err_total++;
			results();
		end
	endtask

	// one single-word transfer, address then data phase
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = rsp.hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	function automatic logic [11:0] fa(input logic [11:0] b,
		input int g, input int k);
		fa = b + 12'(g * 16 + k * 4);
	endfunction

	// let the transmit outputs follow the last write
	task automatic settle;
		repeat (2) @(posedge clk);
	endtask

	// offer one frame, expect {hit, idx}; idx ignored on a miss
	task automatic frame(input logic e, input logic [28:0] i,
		input logic [4:0] exp);
		send <= 1'b1;
		ext <= e;
		id <= i;
		@(posedge clk);
		send <= 1'b0;
		repeat (2) @(posedge clk);
		chk({26'h0, acc.valid, acc.hit, exp[4] ? acc.idx : 4'h0},
			{26'h0, 1'b1, exp});
	endtask

	task automatic t_reset;
		rdc(cafb_pkg::ADDR_MODE, 32'h0);
		rdc(cafb_pkg::ADDR_FEN, 32'h103F);
		chk({20'h0, tx.dir, tx.rtr}, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_mode0;
		wr(cafb_pkg::ADDR_DIR, 32'hFF);
		rdc(cafb_pkg::ADDR_DIR, 32'h0);
		wr(L, 32'hFF);
		rdc(L, 32'h0);
		wr(fa(F, 6, 0), 32'hAA);
		rdc(fa(F, 6, 0), 32'h0);
		wr(fa(F, 5, 0), 32'hAA);
		rdc(fa(F, 5, 0), 32'hAA);
		wr(fa(M, 0, 1), 32'hFF);
		rdc(fa(M, 0, 1), 32'hE3);
		wr(fa(F, 5, 1), 32'hFF);
		rdc(fa(F, 5, 1), 32'hEB);
		$display("t_mode0 done");
	endtask

	task automatic t_dirlen;
		wr(cafb_pkg::ADDR_MODE, 32'h1);
		rdc(cafb_pkg::ADDR_DIR, 32'h0);
		wr(cafb_pkg::ADDR_DIR, 32'hFF);
		rdc(cafb_pkg::ADDR_DIR, 32'hFC);
		wr(cafb_pkg::ADDR_DIR, 32'h84);
		settle();
		chk({26'h0, tx.dir}, 32'h21);
		for (int c = 0; c < 16; c++)
		begin
			wr(L, 32'hF0 | c);
			rdc(L, 32'h40 | c);
			settle();
			chk({28'h0, tx.bytes[3:0]}, c > 8 ? 8 : c);
			chk({31'h0, tx.rtr[0]}, 32'h1);
		end
		wr(L + 12'h014, 32'h05);
		settle();
		chk({27'h0, tx.rtr[5], tx.bytes[23:20]}, 32'h05);
		wr(cafb_pkg::ADDR_MODE, 32'h2);
		rdc(cafb_pkg::ADDR_DIR, 32'h84);
		$display("t_dirlen done");
	endtask

	task automatic t_ids;
		logic [11:0] b;
		for (int g = 0; g < 4; g++)
		begin
			b = g < 2 ? fa(F, g * 15, 0) : fa(M, g - 2, 0);
			for (int k = 0; k < 4; k++)
			begin
				wr(b + 12'(4 * k), k == 1 ? 32'hFF : 32'h96 + k);
				rdc(b + 12'(4 * k), k == 1 ? 32'hEB : 32'h96 + k);
			end
		end
		$display("t_ids done");
	endtask

	task automatic t_accept;
		wr(cafb_pkg::ADDR_MODE, 32'h1);
		wr(cafb_pkg::ADDR_FEN, 32'h1);
		wr(fa(M, 0, 0), 32'hFF);
		wr(fa(M, 0, 1), 32'hE8);
		wr(fa(M, 0, 2), 32'h0);
		wr(fa(M, 0, 3), 32'h0);
		wr(fa(F, 0, 0), 32'h12);
		wr(fa(F, 0, 1), 32'h60);
		frame(1'b0, 29'h093, 5'h10);
		frame(1'b0, 29'h092, 5'h00);
		frame(1'b1, {11'h093, 18'h0}, 5'h00);
		wr(fa(M, 0, 1), 32'hE0);
		frame(1'b1, {11'h093, 18'h0}, 5'h10);
		wr(fa(M, 0, 1), 32'h00);
		frame(1'b0, 29'h092, 5'h10);
		// fully open mask 0: any frame lands on filter 0
		wr(fa(M, 0, 0), 32'h00);
		frame(1'b1, X, 5'h10);
		wr(cafb_pkg::ADDR_FEN, 32'h0);
		frame(1'b0, 29'h093, 5'h00);
		// extended filter 2 behind mask 1
		wr(cafb_pkg::ADDR_FEN, 32'h4);
		wr(fa(M, 1, 0), 32'hFF);
		wr(fa(M, 1, 1), 32'hEB);
		wr(fa(M, 1, 2), 32'hFF);
		wr(fa(M, 1, 3), 32'hFF);
		wr(fa(F, 2, 0), 32'hA5);
		wr(fa(F, 2, 1), 32'h69);
		wr(fa(F, 2, 2), 32'h3C);
		wr(fa(F, 2, 3), 32'h81);
		frame(1'b1, X, 5'h12);
		frame(1'b1, X ^ 29'h1, 5'h00);
		frame(1'b0, X, 5'h00);
		wr(cafb_pkg::ADDR_MODE, 32'h0);
		frame(1'b1, X, 5'h12);
		$display("t_accept done");
	endtask

	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	// reset, then the scenarios in turn
	initial
	begin
		{nrst, hsel, hwrite, send, ext} = '0;
		{haddr, hwdata, htrans, id} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_mode0();
		t_dirlen();
		t_ids();
		t_accept();
		results();
	end
endmodule // cafb_top_tb_top
